// ---- timer_flag_defs.svh ----
// register offsets, field positions and reset values of the timer flag block
`ifndef TIMER_FLAG_DEFS_SVH
`define TIMER_FLAG_DEFS_SVH
`define NUM_CHANNELS 2
`define OFF_CONTROL 12'h000
`define OFF_MODULUS 12'h004
`define OFF_COUNT 12'h008
`define OFF_FLAGS 12'h00c
`define OFF_CH0_CTRL 12'h010
`define OFF_CH0_VALUE 12'h014
`define OFF_CH1_CTRL 12'h018
`define OFF_CH1_VALUE 12'h01c
`define OFF_IRQ_STATUS 12'h020
`define OFF_IRQ_ENABLE 12'h024
`define OFF_IRQ_CLEAR 12'h028
`define CTRL_RUN_BIT 0
`define CTRL_CENTER_BIT 1
`define CTRL_WRAP_IE_BIT 2
`define CHC_ELS_LOW_BIT 0
`define CHC_ELS_HIGH_BIT 1
`define CHC_MODE_LSB 2
`define CHC_IE_BIT 4
`define FLAG_WRAP_BIT 0
`define FLAG_CH0_BIT 1
`define COUNT_ZERO 16'h0000
`define COUNT_TOP 16'hffff
`define MODULUS_RESET 16'h0000
`define VALUE_RESET 16'h0000
`define EVENT_BITS 3
`endif

// ---- timer_flag_pkg.sv ----
// types shared by the timer flag block
package timer_flag_pkg;
   typedef enum logic [1:0] {
      CH_CAPTURE = 2'b00,
      CH_COMPARE = 2'b01,
      CH_EDGE_PWM = 2'b11,
      CH_OFF = 2'b10
   } ch_mode_type;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;
   typedef struct packed {
      logic edge_level_select_high;
      logic edge_level_select_low;
      ch_mode_type mode;
      logic channel_event_irq_enable;
   } ch_ctrl_type;
endpackage

// ---- flag_cell.sv ----
// one timer flag with two-step clear: armed by a read while set, cleared by a write of zero
`timescale 1ns/1ns
module flag_cell (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic set_evt,
   input wire logic read_evt,
   input wire logic clear_evt,
   output logic flag
);
   logic flag_r, flag_nxt;
   logic armed_r, armed_nxt;
   always_comb begin
      flag_nxt = flag_r;
      armed_nxt = armed_r;
      if (read_evt && flag_r) begin
         armed_nxt = 1'b1;
      end
      if (clear_evt && armed_r) begin
         flag_nxt = 1'b0;
         armed_nxt = 1'b0;
      end
      // a new event restarts the sequence and beats the clear
      if (set_evt) begin
         flag_nxt = 1'b1; // [RQ11]
         armed_nxt = 1'b0; // [RQ11]
      end
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         flag_r <= 1'b0; // [RQ15]
         armed_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
         armed_r <= armed_nxt;
      end
   end
   assign flag = flag_r;
endmodule

// ---- timer_event_flag_logic.sv ----
// timer counter with wrap and channel event flags, APB registers and interrupt
// What this block does
// [RQ1] free up-count steps 0x0000 to 0xffff then wraps to 0x0000
// [RQ2] free up-count sets wrap flag on the 0xffff to 0x0000 step
// [RQ3] nonzero modulus: wrap flag set on modulus to 0x0000 step
// [RQ4] up/down: wrap flag set when leaving modulus downward
// [RQ5] capture edge chosen by two select bits: rise, fall, both, none
// [RQ6] capture channel sets event flag on selected edge
// [RQ7] compare channel sets event flag when counter equals channel value
// [RQ8] edge pwm sets event flag on match, end of duty
// [RQ9] center pwm sets event flag on both matches, up and down
// [RQ10] channel flags clear only through the common two-step sequence
// [RQ11] read while set then write zero clears; new event keeps flag
// [RQ12] interrupt level high while an enabled flag reads one; the code also raises it for enabled irq_status_r bits
// [RQ13] center align select: zero up-count, one up/down count
// [RQ14] up/down counts up to modulus, down to zero, repeats
// [RQ15] flags set regardless of enables; reset clears all flags
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "timer_flag_defs.svh"
module timer_event_flag_logic
   import timer_flag_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [`NUM_CHANNELS-1:0] channel_in,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic timer_irq
);
   localparam int NC = `NUM_CHANNELS;
   localparam int NF = NC + 1;

   function automatic logic [31:0] ch_ctrl_word(input ch_ctrl_type c);
      ch_ctrl_word = 32'h0000_0000;
      ch_ctrl_word[`CHC_ELS_LOW_BIT] = c.edge_level_select_low;
      ch_ctrl_word[`CHC_ELS_HIGH_BIT] = c.edge_level_select_high;
      ch_ctrl_word[`CHC_MODE_LSB +: 2] = c.mode;
      ch_ctrl_word[`CHC_IE_BIT] = c.channel_event_irq_enable;
   endfunction

   apb_req_type req;
   assign req = '{psel, penable, pwrite, paddr, pwdata};
   logic acc;
   assign acc = req.psel && req.penable;

   // control state
   logic run_r, run_nxt;
   logic center_align_select_r, center_align_select_nxt;
   logic counter_wrap_irq_enable_r, counter_wrap_irq_enable_nxt;
   logic [15:0] modulus_r, modulus_nxt;
   ch_ctrl_type ch_ctrl_r [NC];
   ch_ctrl_type ch_ctrl_nxt [NC];
   logic [15:0] ch_value_r [NC];
   logic [15:0] ch_value_nxt [NC];
   logic [`EVENT_BITS-1:0] irq_enable_r, irq_enable_nxt;
   logic [`EVENT_BITS-1:0] irq_status_r, irq_status_nxt;

   // counter state
   logic [15:0] count_r, count_nxt;
   logic down_r, down_nxt;
   logic [NC-1:0] in_prev_r, in_prev_nxt;

   // bus and interrupt outputs
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic irq_r, irq_nxt;

   // flag events
   logic [NF-1:0] set_ev, read_ev, clear_ev, flags;
   logic [NF-1:0] flags_prev_r;

   genvar g;
   generate
      for (g = 0; g < NF; g++) begin : gen_flag
         flag_cell u_flag (
            .core_clk(core_clk),
            .reset_n(reset_n),
            .set_evt(set_ev[g]),
            .read_evt(read_ev[g]),
            .clear_evt(clear_ev[g]),
            .flag(flags[g])
         );
      end
   endgenerate

   // counter and event detection
   logic wrap_ev;
   logic [NC-1:0] ch_ev;
   always_comb begin
      count_nxt = count_r;
      down_nxt = down_r;
      wrap_ev = 1'b0;
      if (run_r) begin
         if (!center_align_select_r) begin // [RQ13]
            down_nxt = 1'b0;
            if ((modulus_r != `COUNT_ZERO && count_r == modulus_r) ||
                count_r == `COUNT_TOP) begin
               count_nxt = `COUNT_ZERO; // [RQ1] [RQ3]
               wrap_ev = 1'b1; // [RQ2] [RQ3]
            end else begin
               count_nxt = count_r + 16'h0001; // [RQ1]
            end
         end else if (!down_r) begin
            if (count_r >= modulus_r) begin
               // direction reversal: end of period
               down_nxt = 1'b1; // [RQ14]
               count_nxt = count_r - 16'h0001;
               wrap_ev = 1'b1; // [RQ4]
            end else begin
               count_nxt = count_r + 16'h0001; // [RQ14]
            end
         end else begin
            if (count_r == `COUNT_ZERO || count_r == 16'h0001) begin
               down_nxt = 1'b0; // [RQ14]
            end
            count_nxt = (count_r == `COUNT_ZERO) ? 16'h0001 : count_r - 16'h0001;
         end
      end
   end

   always_comb begin
      in_prev_nxt = channel_in;
      for (int i = 0; i < NC; i++) begin
         ch_ev[i] = 1'b0;
         case (ch_ctrl_r[i].mode)
            CH_CAPTURE: begin
               // [RQ5] select bits: 01 rise, 10 fall, 11 both, 00 off
               ch_ev[i] = (ch_ctrl_r[i].edge_level_select_low &&
                           channel_in[i] && !in_prev_r[i]) ||
                          (ch_ctrl_r[i].edge_level_select_high &&
                           !channel_in[i] && in_prev_r[i]); // [RQ6]
            end
            CH_COMPARE, CH_EDGE_PWM: begin
               // in center mode a match occurs once up and once down
               ch_ev[i] = run_r && count_r == ch_value_r[i]; // [RQ7] [RQ8] [RQ9]
            end
            default: ch_ev[i] = 1'b0;
         endcase
      end
   end

   // register bus
   always_comb begin
      run_nxt = run_r;
      center_align_select_nxt = center_align_select_r;
      counter_wrap_irq_enable_nxt = counter_wrap_irq_enable_r;
      modulus_nxt = modulus_r;
      ch_ctrl_nxt = ch_ctrl_r;
      ch_value_nxt = ch_value_r;
      irq_enable_nxt = irq_enable_r;
      prdata_nxt = prdata_r;
      pready_nxt = 1'b0;
      pslverr_nxt = 1'b0;
      read_ev = '0;
      clear_ev = '0;
      set_ev = {ch_ev, wrap_ev}; // [RQ15]
      irq_status_nxt = irq_status_r | {ch_ev, wrap_ev};
      // single wait state: answer in second access cycle
      if (acc && !pready_r) begin
         pready_nxt = 1'b1;
         prdata_nxt = 32'h0000_0000;
         case (req.paddr)
            `OFF_CONTROL: begin
               prdata_nxt[`CTRL_RUN_BIT] = run_r;
               prdata_nxt[`CTRL_CENTER_BIT] = center_align_select_r;
               prdata_nxt[`CTRL_WRAP_IE_BIT] = counter_wrap_irq_enable_r;
               if (req.pwrite) begin
                  run_nxt = req.pwdata[`CTRL_RUN_BIT];
                  center_align_select_nxt = req.pwdata[`CTRL_CENTER_BIT];
                  counter_wrap_irq_enable_nxt = req.pwdata[`CTRL_WRAP_IE_BIT];
               end
            end
            `OFF_MODULUS: begin
               prdata_nxt[15:0] = modulus_r;
               if (req.pwrite) modulus_nxt = req.pwdata[15:0];
            end
            `OFF_COUNT: prdata_nxt[15:0] = count_r;
            `OFF_FLAGS: begin
               prdata_nxt[NF-1:0] = flags;
               if (req.pwrite) begin
                  clear_ev = ~req.pwdata[NF-1:0]; // [RQ10] [RQ11]
               end else begin
                  read_ev = flags; // [RQ11]
               end
            end
            `OFF_CH0_CTRL, `OFF_CH1_CTRL: begin
               prdata_nxt = ch_ctrl_word(ch_ctrl_r[req.paddr[3]]);
               if (req.pwrite) begin
                  ch_ctrl_nxt[req.paddr[3]] = '{req.pwdata[`CHC_ELS_HIGH_BIT],
                     req.pwdata[`CHC_ELS_LOW_BIT],
                     ch_mode_type'(req.pwdata[`CHC_MODE_LSB +: 2]),
                     req.pwdata[`CHC_IE_BIT]};
               end
            end
            `OFF_CH0_VALUE, `OFF_CH1_VALUE: begin
               prdata_nxt[15:0] = ch_value_r[req.paddr[3]];
               if (req.pwrite) ch_value_nxt[req.paddr[3]] = req.pwdata[15:0];
            end
            `OFF_IRQ_STATUS: prdata_nxt[NF-1:0] = irq_status_r;
            `OFF_IRQ_ENABLE: begin
               prdata_nxt[NF-1:0] = irq_enable_r;
               if (req.pwrite) irq_enable_nxt = req.pwdata[NF-1:0];
            end
            `OFF_IRQ_CLEAR: begin
               if (req.pwrite) begin
                  // set beats clear
                  irq_status_nxt = (irq_status_r & ~req.pwdata[NF-1:0]) |
                     {ch_ev, wrap_ev};
               end
            end
            default: pslverr_nxt = 1'b1;
         endcase
      end
      // interrupt: timer flags gated by their enables, plus status register path
      irq_nxt = |(flags_prev_r & {ch_ctrl_r[1].channel_event_irq_enable,
                                  ch_ctrl_r[0].channel_event_irq_enable,
                                  counter_wrap_irq_enable_r}) |
                |(irq_status_r & irq_enable_r); // [RQ12]
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         run_r <= 1'b0;
         center_align_select_r <= 1'b0;
         counter_wrap_irq_enable_r <= 1'b0;
         modulus_r <= `MODULUS_RESET;
         for (int i = 0; i < NC; i++) begin
            ch_ctrl_r[i] <= '{1'b0, 1'b0, CH_CAPTURE, 1'b0};
            ch_value_r[i] <= `VALUE_RESET;
         end
         irq_enable_r <= '0;
         irq_status_r <= '0; // [RQ15]
         count_r <= `COUNT_ZERO;
         down_r <= 1'b0;
         in_prev_r <= '0;
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         irq_r <= 1'b0;
         flags_prev_r <= '0;
      end else begin
         run_r <= run_nxt;
         center_align_select_r <= center_align_select_nxt;
         counter_wrap_irq_enable_r <= counter_wrap_irq_enable_nxt;
         modulus_r <= modulus_nxt;
         ch_ctrl_r <= ch_ctrl_nxt;
         ch_value_r <= ch_value_nxt;
         irq_enable_r <= irq_enable_nxt;
         irq_status_r <= irq_status_nxt;
         count_r <= count_nxt;
         down_r <= down_nxt;
         in_prev_r <= in_prev_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         irq_r <= irq_nxt;
         flags_prev_r <= flags;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign timer_irq = irq_r;
endmodule

// ---- timer_flag_props.sv ----
// checker of the timer flag block bus answers and interrupt level
`timescale 1ns/1ns
`include "timer_flag_defs.svh"
module timer_flag_props (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic timer_irq
);
   logic acc, rdq, ok, en_r, en_nxt;
   assign acc = psel && penable;
   assign rdq = pready && !pwrite;
   assign ok = paddr[1:0] == 2'h0 && paddr <= `OFF_IRQ_CLEAR;
   // sticky: an enable once written may keep the irq up, so only the quiet case is checked
   always_comb begin
      en_nxt = en_r;
      if (pready && pwrite && ((paddr == `OFF_CONTROL && pwdata[2]) ||
         (paddr inside {`OFF_CH0_CTRL, `OFF_CH1_CTRL} && pwdata[4]) ||
         (paddr == `OFF_IRQ_ENABLE && pwdata[2:0] != 3'h0)))
         en_nxt = 1'b1;
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n)
         en_r <= 1'b0;
      else
         en_r <= en_nxt;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
   chk_ready_in_access: assert property (pready |-> acc) else $error("pready outside access");
   chk_ready_bound: assert property (acc && !pready |-> ##[1:2] pready)
      else $error("pready late");
   chk_err_with_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
   chk_unmapped_err: assert property (pready && !ok |-> pslverr) else $error("no pslverr");
   chk_mapped_ok: assert property (pready && ok |-> !pslverr) else $error("bad pslverr");
   chk_clear_reads_zero: assert property (rdq && paddr == `OFF_IRQ_CLEAR |-> prdata == 32'h0)
      else $error("clear reg read not zero");
   chk_flag_width: assert property (rdq && paddr inside {`OFF_FLAGS, `OFF_IRQ_STATUS} |->
      prdata[31:3] == 29'h0) else $error("flag upper bits set");
   chk_irq_quiet: assert property (!en_r |-> !timer_irq)
      else $error("irq without enable");
   cover property (pready && pwrite);
   cover property (pslverr);
   cover property ($rose(timer_irq));
endmodule
bind timer_event_flag_logic timer_flag_props u_props (.core_clk, .reset_n, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_irq);

// ---- signal_source.sv ----
// channel pin source: replays requested levels after a chosen lag
`timescale 1ns/1ns
module signal_source (
   input wire logic core_clk,
   input wire logic [1:0] level_req,
   input wire logic [3:0] lag,
   output logic [1:0] channel_in
);
   logic [1:0] pipe_r [16];
   // a slow source stretches the gap between the two clearing steps
   always_ff @(posedge core_clk) begin
      pipe_r[0] <= level_req;
      for (int i = 1; i < 16; i++)
         pipe_r[i] <= pipe_r[i-1];
   end
   assign channel_in = (lag == 4'h0) ? level_req : pipe_r[lag-4'h1];
endmodule

// ---- timer_event_flag_logic_test.sv ----
// self-checking bench of the timer flag block
`timescale 1ns/1ns
`include "timer_flag_defs.svh"
module timer_event_flag_logic_test
   import timer_flag_pkg::*;
();
   logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, timer_irq, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, c;
   logic [1:0] lvl, channel_in;
   logic [3:0] lag;
   logic [11:0] zoff [5] = '{`OFF_FLAGS, `OFF_IRQ_STATUS, `OFF_MODULUS, `OFF_CH0_VALUE,
      `OFF_CH1_VALUE};
   int err_count = 0;
   int tests_run = 0;
   int cyc = 0;
   int n [3];
   timer_event_flag_logic uut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .channel_in(channel_in), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_irq(timer_irq));
   signal_source src (.core_clk(core_clk), .level_req(lvl), .lag(lag),
      .channel_in(channel_in));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic wait_n(input int k);
      repeat (k) @(posedge core_clk);
   endtask
   task automatic drive(input logic [1:0] v);
      lvl <= v;
      wait_n(lag + 6);
   endtask
   // counts flag events in a window; poll spacing limits accuracy to one event
   task automatic poll(input int k);
      int stop;
      stop = cyc + k;
      n = '{0, 0, 0};
      while (cyc < stop) begin
         apb(1'b0, `OFF_FLAGS, 32'h0);
         for (int i = 0; i < 3; i++)
            if (rd[i] === 1'b1)
               n[i]++;
         apb(1'b1, `OFF_FLAGS, 32'h0);
      end
   endtask
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         err_count++;
         print_verdict();
      end
   end
   initial begin
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      lvl = 2'b00;
      lag = 4'h0;
      wait_n(8);
      reset_n <= 1'b1;
      @(posedge core_clk);
      foreach (zoff[i])
         rdc(zoff[i], 32'h0);
      apb(1'b0, 12'h030, 32'h0);
      chk(er, 1'b1);
      apb(1'b1, `OFF_CONTROL, 32'h1);
      wait_n(65000);
      rdc(`OFF_FLAGS, 32'h0);
      wait_n(540);
      apb(1'b1, `OFF_CONTROL, 32'h0);
      rdc(`OFF_FLAGS, 32'h1);
      apb(1'b0, `OFF_COUNT, 32'h0);
      c = rd;
      chk(c < 32'h40, 1'b1);
      apb(1'b1, `OFF_COUNT, 32'h1234);
      rdc(`OFF_COUNT, c);
      apb(1'b1, `OFF_FLAGS, 32'h0);
      rdc(`OFF_FLAGS, 32'h0);
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, `OFF_CH0_CTRL, s);
         drive(2'b01);
         rdc(`OFF_FLAGS, {30'h0, s[0], 1'b0});
         apb(1'b1, `OFF_FLAGS, 32'h0);
         drive(2'b00);
         rdc(`OFF_FLAGS, {30'h0, s[1], 1'b0});
         apb(1'b1, `OFF_FLAGS, 32'h0);
      end
      lag <= 4'h5;
      apb(1'b1, `OFF_CH0_CTRL, 32'h1);
      drive(2'b01);
      apb(1'b1, `OFF_FLAGS, 32'h0);
      rdc(`OFF_FLAGS, 32'h2);
      drive(2'b00);
      drive(2'b01);
      apb(1'b1, `OFF_FLAGS, 32'h0);
      rdc(`OFF_FLAGS, 32'h2);
      apb(1'b1, `OFF_FLAGS, 32'h0);
      rdc(`OFF_FLAGS, 32'h0);
      lag <= 4'h0;
      apb(1'b1, `OFF_MODULUS, 32'd119);
      apb(1'b1, `OFF_CH0_CTRL, {CH_EDGE_PWM, 2'b00});
      apb(1'b1, `OFF_CH0_VALUE, 32'd30);
      apb(1'b1, `OFF_CH1_CTRL, {CH_COMPARE, 2'b00});
      apb(1'b1, `OFF_CH1_VALUE, 32'd50);
      apb(1'b1, `OFF_CONTROL, 32'h1);
      poll(600);
      chk(n[0] inside {[4:6]}, 1'b1);
      chk(n[1] inside {[4:6]}, 1'b1);
      chk(n[2] inside {[4:6]}, 1'b1);
      apb(1'b1, `OFF_CONTROL, 32'h3);
      apb(1'b1, `OFF_MODULUS, 32'd59);
      poll(600);
      chk(n[0] inside {[4:7]}, 1'b1);
      chk(n[1] inside {[9:12]}, 1'b1);
      apb(1'b1, `OFF_CONTROL, 32'h0);
      apb(1'b1, `OFF_CH1_CTRL, 32'h0);
      apb(1'b1, `OFF_CH0_CTRL, 32'h1);
      apb(1'b0, `OFF_FLAGS, 32'h0);
      apb(1'b1, `OFF_FLAGS, 32'h0);
      apb(1'b1, `OFF_IRQ_CLEAR, 32'h7);
      rdc(`OFF_IRQ_STATUS, 32'h0);
      drive(2'b00);
      drive(2'b01);
      rdc(`OFF_IRQ_STATUS, 32'h2);
      chk(timer_irq, 1'b0);
      apb(1'b1, `OFF_IRQ_ENABLE, 32'h2);
      wait_n(3);
      chk(timer_irq, 1'b1);
      apb(1'b1, `OFF_IRQ_ENABLE, 32'h0);
      wait_n(3);
      chk(timer_irq, 1'b0);
      apb(1'b1, `OFF_IRQ_CLEAR, 32'h2);
      rdc(`OFF_IRQ_STATUS, 32'h0);
      apb(1'b1, `OFF_CH0_CTRL, 32'h11);
      wait_n(3);
      chk(timer_irq, 1'b1);
      rdc(`OFF_FLAGS, 32'h2);
      apb(1'b1, `OFF_FLAGS, 32'h0);
      wait_n(3);
      chk(timer_irq, 1'b0);
      print_verdict();
   end
endmodule
